// [logic/sdp_pkg.sv]
// shared constants and types of the single-pin debug port
package sdp_pkg;
  // ***************************************************************
  // link timing
  // ***************************************************************
  localparam int unsigned CLK_HZ     = 20000000;
  localparam int unsigned BAUD_BPS   = 115200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam logic [15:0] BIT_LAST   = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF   = 16'(BIT_CYCLES / 2);
  localparam logic [2:0]  BIT_TOP    = 3'h7;

  // ***************************************************************
  // command codes and control values
  // ***************************************************************
  localparam logic [7:0] CMD_STATUS   = 8'h02;
  localparam logic [7:0] CMD_WR_CTRL  = 8'h04;
  localparam logic [7:0] CMD_STUFF    = 8'h11;
  localparam logic [7:0] CMD_EXEC     = 8'h12;
  localparam logic [7:0] CTRL_RST_HLT = 8'h81;
  localparam logic [7:0] CTRL_RST_RUN = 8'h41;
  localparam logic [7:0] CTRL_RUN     = 8'h40;
  localparam logic [2:0] LEN_MIN      = 3'h1;
  localparam logic [2:0] LEN_MAX      = 3'h5;

  // byte handed to the core for execution
  typedef struct packed {
    logic       valid;
    logic       first_only;
    logic       last;
    logic [7:0] data;
  } sdp_instr_t;

  // state of the core as seen by the debug port
  typedef struct packed {
    logic brk_exec;
    logic in_halt;
    logic in_stop;
    logic wdt_en;
    logic read_prot;
  } sdp_core_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sdp_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sdp_tx_t;
  typedef enum logic [1:0] {CM_CODE, CM_OPND, CM_LEN} sdp_cm_t;
endpackage : sdp_pkg

// [logic/sdp_debug_port.sv]
// single-pin debug port: serial link, command decoder and halt control
`timescale 1ns/1ns
// Behaviour
// - one open-drain pin, driven low only, pull-up gives high, carries both directions.
// - half duplex; never transmit while receiving and vice versa.
// - each byte framed asynchronously with start, data and stop bits.
// - halted: instruction fetch stopped except for bytes the port hands over.
// - halted: system clock keeps running unless in stop mode.
// - halted: enabled peripherals keep running unless in stop mode.
// - entering halt while core is in its halt state wakes the core.
// - halted with watchdog enabled: refresh watchdog continuously.
// - executing a breakpoint instruction enters the halted state.
// - pin low in last reset cycle enters halted state after reset.
// - command 11H plus opcode steps one instruction; rest from program memory.
// - 11H ignored unless halted and read protection off.
// - command 12H plus 1-5 byte instruction executes it on the core.
// - 12H when not halted or protected reads and drops one byte.
// - control 81H resets and halts, 41H resets and runs, 40H resumes.
module sdp_debug_port
  import sdp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        debug_serial_pin_in,
  output logic             debug_serial_pin_out,
  output logic             debug_serial_pin_oe,
  input  wire sdp_core_t   core,
  input  wire logic [2:0]  op_len,
  output sdp_instr_t       instr,
  output logic             halted,
  output logic             fetch_stop,
  output logic             clk_run,
  output logic             periph_run,
  output logic             halt_exit,
  output logic             wdt_refresh,
  output logic             sys_reset_req
);

  // ***************************************************************
  // receiver
  // ***************************************************************
  sdp_rx_t     rx_st,  next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_sh,  next_rx_sh;
  logic        rx_arm, next_rx_arm;
  logic        rx_vld, next_rx_vld;
  sdp_tx_t     tx_st;

  always_comb begin
    next_rx_st  = rx_st;
    next_rx_cnt = rx_cnt + 16'h0001;
    next_rx_bit = rx_bit;
    next_rx_sh  = rx_sh;
    next_rx_vld = 1'b0;
    // a low pin held from reset is not a start bit: wait for idle high first
    next_rx_arm = rx_arm | debug_serial_pin_in;
    unique case (rx_st)
      RX_IDLE: begin
        next_rx_cnt = 16'h0000;
        // own transmission is never read back as a command
        if (rx_arm && !debug_serial_pin_in && tx_st == TX_IDLE) begin
          next_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt == BIT_HALF) begin
          next_rx_cnt = 16'h0000;
          next_rx_bit = 3'h0;
          next_rx_st  = debug_serial_pin_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt == BIT_LAST) begin
          next_rx_cnt = 16'h0000;
          next_rx_sh  = {debug_serial_pin_in, rx_sh[7:1]};
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == BIT_TOP) begin
            next_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt == BIT_LAST) begin
          // a missing stop bit drops the byte
          next_rx_vld = debug_serial_pin_in;
          next_rx_arm = debug_serial_pin_in;
          next_rx_st  = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_sh  <= 8'h00;
      rx_arm <= 1'b0;
      rx_vld <= 1'b0;
    end else begin
      rx_st  <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh  <= next_rx_sh;
      rx_arm <= next_rx_arm;
      rx_vld <= next_rx_vld;
    end
  end

  // ***************************************************************
  // transmitter
  // ***************************************************************
  sdp_tx_t     next_tx_st;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [2:0]  tx_bit, next_tx_bit;
  logic [7:0]  tx_sh,  next_tx_sh;
  logic        next_oe;
  logic        tx_go;
  logic [7:0]  tx_byte;

  always_comb begin
    next_tx_st  = tx_st;
    next_tx_cnt = tx_cnt + 16'h0001;
    next_tx_bit = tx_bit;
    next_tx_sh  = tx_sh;
    unique case (tx_st)
      TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        if (tx_go) begin
          next_tx_sh = tx_byte;
          next_tx_st = TX_START;
        end
      end
      TX_START: begin
        if (tx_cnt == BIT_LAST) begin
          next_tx_cnt = 16'h0000;
          next_tx_bit = 3'h0;
          next_tx_st  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_cnt == BIT_LAST) begin
          next_tx_cnt = 16'h0000;
          next_tx_sh  = {1'b1, tx_sh[7:1]};
          next_tx_bit = tx_bit + 3'h1;
          if (tx_bit == BIT_TOP) begin
            next_tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tx_cnt == BIT_LAST) begin
          next_tx_st = TX_IDLE;
        end
      end
    endcase
    // only a low is ever driven; the pull-up makes the high
    next_oe = (next_tx_st == TX_START) ||
              (next_tx_st == TX_DATA && !next_tx_sh[0]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st               <= TX_IDLE;
      tx_cnt              <= 16'h0000;
      tx_bit              <= 3'h0;
      tx_sh               <= 8'h00;
      debug_serial_pin_oe <= 1'b0;
    end else begin
      tx_st               <= next_tx_st;
      tx_cnt              <= next_tx_cnt;
      tx_bit              <= next_tx_bit;
      tx_sh               <= next_tx_sh;
      debug_serial_pin_oe <= next_oe;
    end
  end

  // ***************************************************************
  // command decoder and halt control
  // ***************************************************************
  sdp_cm_t    cm_st, next_cm_st;
  logic [7:0] cmd, next_cmd;
  logic [2:0] need, next_need;
  logic       drop, next_drop;
  logic       boot, next_boot;
  logic       next_halted;
  logic       next_rst;
  sdp_instr_t next_instr;
  logic       allowed;

  always_comb begin
    next_cm_st  = cm_st;
    next_cmd    = cmd;
    next_need   = need;
    next_drop   = drop;
    next_boot   = 1'b0;
    next_halted = halted;
    next_rst    = 1'b0;
    next_instr  = '{valid: 1'b0, first_only: 1'b0, last: 1'b0, data: instr.data};
    tx_go       = 1'b0;
    tx_byte     = {6'h00, core.read_prot, halted};
    allowed     = halted && !core.read_prot;
    unique case (cm_st)
      CM_CODE: begin
        if (rx_vld) begin
          next_cmd = rx_sh;
          unique case (rx_sh)
            CMD_STATUS: tx_go = 1'b1;
            CMD_WR_CTRL, CMD_STUFF, CMD_EXEC: begin
              next_drop  = 1'b0;
              next_cm_st = CM_OPND;
            end
            default: begin
            end
          endcase
        end
      end
      CM_OPND: begin
        if (rx_vld) begin
          next_cm_st = CM_CODE;
          unique case (cmd)
            CMD_WR_CTRL: begin
              if (rx_sh == CTRL_RST_HLT) begin
                next_rst    = 1'b1;
                next_halted = 1'b1;
              end else if (rx_sh == CTRL_RST_RUN) begin
                next_rst    = 1'b1;
                next_halted = 1'b0;
              end else if (rx_sh == CTRL_RUN && halted) begin
                next_halted = 1'b0;
              end
            end
            CMD_STUFF: begin
              // core fetches the remaining bytes itself
              if (allowed) begin
                next_instr = '{valid: 1'b1, first_only: 1'b1, last: 1'b1, data: rx_sh};
              end
            end
            default: begin
              // remaining bytes of an executed instruction go straight to the core
              if (drop) begin
                next_need  = need - 3'h1;
                next_instr = '{valid: 1'b1, first_only: 1'b0, last: (need == 3'h1), data: rx_sh};
                if (need != 3'h1) begin
                  next_cm_st = CM_OPND;
                end
              end else if (allowed) begin
                next_instr.data = rx_sh;
                next_cm_st      = CM_LEN;
              end
              // refused: the single byte read here is simply dropped
            end
          endcase
        end
      end
      CM_LEN: begin
        // opcode held back one cycle so that its one pulse carries the last flag
        next_instr = '{valid: 1'b1, first_only: 1'b0, last: 1'b1, data: instr.data};
        if (op_len > LEN_MIN && op_len <= LEN_MAX) begin
          next_instr.last = 1'b0;
          next_need       = op_len - 3'h1;
          next_drop       = 1'b1;
          next_cm_st      = CM_OPND;
        end else begin
          next_cm_st = CM_CODE;
        end
      end
    endcase
    // set wins over a run command in the same cycle
    if (boot && !debug_serial_pin_in) begin
      next_halted = 1'b1;
    end
    if (core.brk_exec) begin
      next_halted = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cm_st         <= CM_CODE;
      cmd           <= 8'h00;
      need          <= 3'h0;
      drop          <= 1'b0;
      boot          <= 1'b1;
      halted        <= 1'b0;
      sys_reset_req <= 1'b0;
      instr         <= '0;
    end else begin
      cm_st         <= next_cm_st;
      cmd           <= next_cmd;
      need          <= next_need;
      drop          <= next_drop;
      boot          <= next_boot;
      halted        <= next_halted;
      sys_reset_req <= next_rst;
      instr         <= next_instr;
    end
  end

  // ***************************************************************
  // core side effects of the halted state
  // ***************************************************************
  logic next_fetch_stop;
  logic next_halt_exit;
  logic next_wdt;

  always_comb begin
    // stuffed bytes flow through instr even while fetch is held
    next_fetch_stop = next_halted;
    next_halt_exit  = next_halted && core.in_halt;
    next_wdt        = next_halted && core.wdt_en;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_serial_pin_out <= 1'b0;
      fetch_stop           <= 1'b0;
      clk_run              <= 1'b1;
      periph_run           <= 1'b1;
      halt_exit            <= 1'b0;
      wdt_refresh          <= 1'b0;
    end else begin
      debug_serial_pin_out <= 1'b0;
      fetch_stop           <= next_fetch_stop;
      // debug never gates clocks; only stop mode does
      clk_run              <= !core.in_stop;
      periph_run           <= !core.in_stop;
      halt_exit            <= next_halt_exit;
      wdt_refresh          <= next_wdt;
    end
  end

endmodule : sdp_debug_port

// [dv/sdp_debug_port_monitor.sv]
// concurrent checks on the single-pin debug port
`timescale 1ns/1ns
module sdp_debug_port_monitor
  import sdp_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       debug_serial_pin_in,
  input wire logic       debug_serial_pin_out,
  input wire logic       debug_serial_pin_oe,
  input wire sdp_core_t  core,
  input wire logic [2:0] op_len,
  input wire sdp_instr_t instr,
  input wire logic       halted,
  input wire logic       fetch_stop,
  input wire logic       clk_run,
  input wire logic       periph_run,
  input wire logic       halt_exit,
  input wire logic       wdt_refresh,
  input wire logic       sys_reset_req
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_pin_drive_low: assert property (debug_serial_pin_out == 1'b0)
    else $error("pin driven high");
  chk_tx_when_idle: assert property ($rose(debug_serial_pin_oe) |-> $past(debug_serial_pin_in))
    else $error("transmit began while line busy");
  chk_start_bit_width: assert property ($rose(debug_serial_pin_oe) |-> debug_serial_pin_oe[*8])
    else $error("start bit too short");
  chk_fetch_stop_halt: assert property (fetch_stop == halted)
    else $error("fetch stop differs from halt");
  chk_clock_keeps: assert property (1'b1 |=> clk_run == !$past(core.in_stop))
    else $error("clock run wrong");
  chk_periph_keeps: assert property (1'b1 |=> periph_run == !$past(core.in_stop))
    else $error("peripheral run wrong");
  chk_halt_wakes: assert property ((halted && core.in_halt)[*2] |-> halt_exit)
    else $error("core not woken");
  chk_wdt_kicked: assert property ((halted && core.wdt_en)[*2] |-> wdt_refresh)
    else $error("watchdog not refreshed");
  chk_brk_enters: assert property (core.brk_exec |=> halted)
    else $error("breakpoint did not halt");
  chk_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request too long");
  chk_instr_pulse: assert property (instr.valid |=> !instr.valid)
    else $error("instruction byte repeated");
  cover property ($rose(halted));
  cover property (instr.valid && instr.last);
  cover property (sys_reset_req);
  cover property ($rose(debug_serial_pin_oe));
endmodule : sdp_debug_port_monitor

// [dv/sdp_host_model.sv]
// debug host model on the open-drain serial pin
`timescale 1ns/1ns
module sdp_host_model
  import sdp_pkg::*;
(
  input  wire logic clk,
  input  wire logic pin,
  output logic      host_low
);
  // released line: the pull-up makes it high
  initial host_low = 1'b0;

  task automatic pull_low(input logic on);
    host_low = on;
  endtask : pull_low

  // short stop when a reply follows, so the listener is ready
  task automatic send_byte(input logic [7:0] b, input logic reply);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk);
    #1;
    for (int i = 0; i < 10; i++) begin
      host_low = !f[i];
      repeat ((i == 9 && reply) ? 60 : BIT_CYCLES) @(posedge clk);
      #1;
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b);
    int  n;
    logic bad;
    n = 0;
    while (pin !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge clk);
    bad = (pin !== 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = pin;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    if (bad || pin !== 1'b1) b = 8'hxx;
    repeat (BIT_CYCLES / 2 + 4) @(posedge clk);
    #1;
  endtask : recv_byte
endmodule : sdp_host_model

// [dv/tb_top.sv]
// self-checking testbench of the single-pin debug port
`timescale 1ns/1ns
module tb_top
  import sdp_pkg::*;
;
  logic       clk, arst_n, host_low, pin_out, pin_oe;
  wire        pin;
  sdp_core_t  core;
  logic [2:0] op_len;
  sdp_instr_t instr;
  logic       halted, fetch_stop, clk_run, periph_run, halt_exit, wdt_refresh, sys_reset_req;
  int         mismatches, tests_run, resets, len;
  sdp_instr_t got[$];
  logic [7:0] b[5];
  logic [7:0] rb;

  assign pin = !(pin_oe || host_low);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (instr.valid === 1'b1) got.push_back(instr);
    if (sys_reset_req === 1'b1) resets++;
  end

  sdp_debug_port dut_u (.clk(clk), .arst_n(arst_n), .debug_serial_pin_in(pin),
    .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe), .core(core),
    .op_len(op_len), .instr(instr), .halted(halted), .fetch_stop(fetch_stop),
    .clk_run(clk_run), .periph_run(periph_run), .halt_exit(halt_exit),
    .wdt_refresh(wdt_refresh), .sys_reset_req(sys_reset_req));
  sdp_host_model host_u (.clk(clk), .pin(pin), .host_low(host_low));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  function automatic sdp_instr_t mk(logic fo, logic last, logic [7:0] d);
    mk = '{1'b1, fo, last, d};
  endfunction : mk

  task automatic tx(input logic [7:0] v);
    host_u.send_byte(v, 1'b0);
    repeat ($urandom_range(0, 30)) begin
      @(posedge clk);
      #1;
    end
  endtask : tx

  task automatic status(input logic [7:0] exp);
    host_u.send_byte(CMD_STATUS, 1'b1);
    host_u.recv_byte(rb);
    check(rb, exp);
  endtask : status

  task automatic set_core(input logic rp, input logic hx);
    core = '{1'b0, 1'($urandom), 1'($urandom), 1'($urandom), rp};
    repeat (2) @(posedge clk);
    #1;
    check(clk_run, !core.in_stop);
    check(periph_run, !core.in_stop);
    check(fetch_stop, hx);
    check(halt_exit, hx & core.in_halt);
    check(wdt_refresh, hx & core.wdt_en);
  endtask : set_core

  task automatic do_reset(input logic low);
    @(posedge clk);
    #1 arst_n = 1'b0;
    host_u.pull_low(low);
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (low ? 5000 : 0) @(posedge clk);
    #1 host_u.pull_low(1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    core = '0;
    op_len = 3'h1;
    mismatches = 0;
    tests_run = 0;
    resets = 0;
    void'($urandom(13385));
    do_reset(1'b1);
    check(halted, 1'b1);
    check(fetch_stop, 1'b1);
    set_core(1'b0, 1'b1);
    status(8'h01);
    repeat (2) begin
      len = $urandom_range(1, 5);
      op_len = 3'(len);
      got.delete();
      tx(CMD_EXEC);
      for (int i = 0; i < len; i++) begin
        b[i] = 8'($urandom);
        tx(b[i]);
      end
      check(got.size(), len);
      for (int i = 0; i < len; i++) check(got[i], mk(1'b0, i == len - 1, b[i]));
    end
    got.delete();
    b[0] = 8'($urandom);
    tx(CMD_STUFF);
    tx(b[0]);
    check(got.size(), 1);
    check({got[0].first_only, got[0].data}, {1'b1, b[0]});
    tx(CMD_WR_CTRL);
    tx(CTRL_RUN);
    check({halted, fetch_stop}, 2'h0);
    got.delete();
    tx(CMD_STUFF);
    tx(8'($urandom));
    tx(CMD_EXEC);
    tx(8'($urandom));
    check(got.size(), 0);
    status(8'h00);
    @(posedge clk);
    #1 core.brk_exec = 1'b1;
    @(posedge clk);
    #1 core.brk_exec = 1'b0;
    check(halted, 1'b1);
    set_core(1'b1, 1'b1);
    tx(CMD_EXEC);
    tx(8'($urandom));
    check(got.size(), 0);
    status(8'h03);
    set_core(1'b0, 1'b1);
    resets = 0;
    tx(CMD_WR_CTRL);
    tx(CTRL_RST_RUN);
    check(resets, 32'd1);
    check(halted, 1'b0);
    tx(CMD_WR_CTRL);
    tx(CTRL_RST_HLT);
    check(resets, 32'd2);
    check(halted, 1'b1);
    do_reset(1'b0);
    check(halted, 1'b0);
    conclude;
  end

  initial begin
    repeat (98000) @(posedge clk);
    mismatches++;
    conclude;
  end
endmodule : tb_top

bind sdp_debug_port sdp_debug_port_monitor mon_u (.clk(clk), .arst_n(arst_n),
  .debug_serial_pin_in(debug_serial_pin_in), .debug_serial_pin_out(debug_serial_pin_out),
  .debug_serial_pin_oe(debug_serial_pin_oe), .core(core), .op_len(op_len), .instr(instr),
  .halted(halted), .fetch_stop(fetch_stop), .clk_run(clk_run), .periph_run(periph_run),
  .halt_exit(halt_exit), .wdt_refresh(wdt_refresh), .sys_reset_req(sys_reset_req));
